// *** nchbp_pkg.sv ***
package nchbp_pkg;
    localparam int ADDR_W          = 24;
    localparam int DATA_W          = 16;
    localparam int HI_ADDR_W       = 8;
    localparam int NUM_FLAGS       = 6;
    // Interrupt flag indices
    localparam int FLG_BABBLE      = 0;
    localparam int FLG_MISS        = 1;
    localparam int FLG_MEMERR      = 2;
    localparam int FLG_RXDONE      = 3;
    localparam int FLG_TXDONE      = 4;
    localparam int FLG_INITDONE    = 5;
    // Primary control/status bit positions
    localparam int CSR_IEN_POS     = 6;
    localparam int CSR_SUM_POS     = 7;
    localparam int CSR_INITDONE_POS = 8;
    localparam int CSR_TXDONE_POS  = 9;
    localparam int CSR_RXDONE_POS  = 10;
    localparam int CSR_MEMERR_POS  = 11;
    localparam int CSR_MISS_POS    = 12;
    localparam int CSR_BABBLE_POS  = 14;
    // Reset values
    localparam logic [NUM_FLAGS-1:0] FLAGS_RST  = 6'h00;
    localparam logic [ADDR_W-1:0]    ADDR_RST   = 24'h00_0000;
    localparam logic [DATA_W-1:0]    DATA_RST   = 16'h0000;
    // Memory handshake timeout
    localparam int CLK_PERIOD_NS   = 8;
    localparam int MEM_TIMEOUT_NS  = 25600;
    localparam int MEM_TIMEOUT_CYC = MEM_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int TMR_W           = 12;

    typedef enum logic [1:0] {
        NCHBP_IDLE = 2'b00,
        NCHBP_ADDR = 2'b01,
        NCHBP_DATA = 2'b10,
        NCHBP_END  = 2'b11
    } nchbp_state_t;
endpackage : nchbp_pkg

// *** nchbp_int_flags.sv ***
`timescale 1ns/1ps
module nchbp_int_flags (
    // Clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            rst,
    // Events and host clears
    input  wire logic [nchbp_pkg::NUM_FLAGS-1:0] flag_set,
    input  wire logic [nchbp_pkg::NUM_FLAGS-1:0] flag_clr,
    input  wire logic                            interrupt_enable_bit,
    // State
    output logic      [nchbp_pkg::NUM_FLAGS-1:0] flags_r,
    output logic                                 attention_request_line_summary,
    output logic                                 attention_active
);
    import nchbp_pkg::*;

    logic [NUM_FLAGS-1:0] flags_nxt;

    genvar i;
    generate
        for (i = 0; i < NUM_FLAGS; i++) begin : g_flag
            // Set beats a clear landing in the same cycle
            always_comb begin
                flags_nxt[i] = flag_set[i] | (flags_r[i] & ~flag_clr[i]);
            end
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    flags_r[i] <= FLAGS_RST[i];
                end else begin
                    flags_r[i] <= flags_nxt[i];
                end
            end
        end
    endgenerate

    assign attention_request_line_summary     = |flags_r;
    assign attention_active = attention_request_line_summary & interrupt_enable_bit;
endmodule : nchbp_int_flags

// *** nchbp_host_port.sv ***
`timescale 1ns/1ps
// Operation
// - Master addresses span a flat 24-bit space.
// - Driven address equals the given buffer pointer, no translation.
// - Byte accesses shown by byte/word select or by byte mask pins.
// - Address strobe active level is programmable.
// - Works on multiplexed or separate address/data buses.
// - Drives direction controls for external address/data transceivers.
// - Flags raised on init, receive, transmit, babble, miss, memory error.
// - Enable bit 6 gates interrupts to the processor.
// - Bit 7 shows any pending condition for polling.
// - Attention line asserts on any flag set while enable is one.
// - Inbound control only during read data; outbound on address and writes.
module nchbp_host_port (
    // Clock and reset
    input  wire logic                              core_clk,
    input  wire logic                              rst,
    // Configuration
    input  wire logic                              byte_sel_style,
    input  wire logic                              as_active_high,
    input  wire logic                              demux_bus,
    input  wire logic                              interrupt_enable_bit,
    // Internal DMA requests
    input  wire logic                              dma_req,
    input  wire logic                              dma_write,
    input  wire logic                              dma_byte,
    input  wire logic [nchbp_pkg::ADDR_W-1:0]      dma_addr,
    input  wire logic [nchbp_pkg::DATA_W-1:0]      dma_wdata,
    output logic                                   dma_ready,
    output logic                                   dma_done,
    output logic                                   dma_error,
    output logic      [nchbp_pkg::DATA_W-1:0]      dma_rdata,
    // Internal events and host flag clears
    input  wire logic [nchbp_pkg::NUM_FLAGS-1:0]   event_set,
    input  wire logic [nchbp_pkg::NUM_FLAGS-1:0]   flag_clr,
    output logic      [nchbp_pkg::DATA_W-1:0]      primary_control_status,
    // Multiplexed address/data pins
    input  wire logic [nchbp_pkg::DATA_W-1:0]      dal_in,
    output logic      [nchbp_pkg::DATA_W-1:0]      dal_out,
    output logic                                   dal_oe,
    // Separate address pins
    output logic      [nchbp_pkg::DATA_W-1:0]      addr_lo_out,
    output logic      [nchbp_pkg::HI_ADDR_W-1:0]   addr_hi_out,
    output logic                                   addr_oe,
    // Bus control pins
    output logic                                   read_out,
    output logic                                   addr_strobe_out,
    output logic                                   data_strobe_n_out,
    output logic                                   byte_pin0_out,
    output logic                                   byte_pin1_out,
    output logic                                   transceiver_inbound_ctl,
    output logic                                   transceiver_outbound_ctl,
    output logic                                   ctl_oe,
    input  wire logic                              ready_n,
    // Open-drain attention pin
    output logic                                   attention_request_line_out,
    output logic                                   attention_request_line_oe
);
    import nchbp_pkg::*;

    nchbp_state_t          state_r,   state_nxt;
    logic [ADDR_W-1:0]     addr_r,    addr_nxt;
    logic [DATA_W-1:0]     wdata_r,   wdata_nxt;
    logic [DATA_W-1:0]     rdata_r,   rdata_nxt;
    logic                  write_r,   write_nxt;
    logic                  byte_r,    byte_nxt;
    logic                  done_r,    done_nxt;
    logic                  err_r,     err_nxt;
    logic [TMR_W-1:0]      tmr_r,     tmr_nxt;
    logic [NUM_FLAGS-1:0]  flags;
    logic [NUM_FLAGS-1:0]  all_set;
    logic                  attention_request_line_summary;
    logic                  attention_active;
    logic                  as_act;
    logic                  master;
    logic                  lo_lane;
    logic                  hi_lane;

    // Bus cycle sequencer
    always_comb begin
        state_nxt = state_r;
        addr_nxt  = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        write_nxt = write_r;
        byte_nxt  = byte_r;
        done_nxt  = 1'b0;
        err_nxt   = 1'b0;
        tmr_nxt   = tmr_r;
        case (state_r)
            NCHBP_IDLE: begin
                if (dma_req) begin
                    addr_nxt  = dma_addr;
                    wdata_nxt = dma_wdata;
                    write_nxt = dma_write;
                    byte_nxt  = dma_byte;
                    tmr_nxt   = '0;
                    state_nxt = NCHBP_ADDR;
                end
            end
            NCHBP_ADDR: begin
                state_nxt = NCHBP_DATA;
            end
            NCHBP_DATA: begin
                if (!ready_n) begin
                    if (!write_r) begin
                        rdata_nxt = dal_in;
                    end
                    done_nxt  = 1'b1;
                    state_nxt = NCHBP_END;
                end else if (tmr_r == TMR_W'(MEM_TIMEOUT_CYC - 1)) begin
                    // No handshake: abandon cycle, raise memory error
                    done_nxt  = 1'b1;
                    err_nxt   = 1'b1;
                    state_nxt = NCHBP_END;
                end else begin
                    tmr_nxt = tmr_r + TMR_W'(1);
                end
            end
            NCHBP_END: begin
                state_nxt = NCHBP_IDLE;
            end
            default: begin
                state_nxt = NCHBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= NCHBP_IDLE;
            addr_r  <= ADDR_RST;
            wdata_r <= DATA_RST;
            rdata_r <= DATA_RST;
            write_r <= 1'b0;
            byte_r  <= 1'b0;
            done_r  <= 1'b0;
            err_r   <= 1'b0;
            tmr_r   <= '0;
        end else begin
            state_r <= state_nxt;
            addr_r  <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            write_r <= write_nxt;
            byte_r  <= byte_nxt;
            done_r  <= done_nxt;
            err_r   <= err_nxt;
            tmr_r   <= tmr_nxt;
        end
    end

    assign dma_ready = (state_r == NCHBP_IDLE);
    assign dma_done  = done_r;
    assign dma_error = err_r;
    assign dma_rdata = rdata_r;

    // Pin drive while master
    assign master  = (state_r == NCHBP_ADDR) | (state_r == NCHBP_DATA);
    assign as_act  = (state_r == NCHBP_ADDR);
    assign ctl_oe  = master;
    assign addr_oe = master;

    assign addr_hi_out = addr_r[ADDR_W-1:DATA_W];
    assign addr_lo_out = addr_r[DATA_W-1:0];

    always_comb begin
        dal_out = DATA_RST;
        dal_oe  = 1'b0;
        if (as_act && !demux_bus) begin
            dal_out = addr_r[DATA_W-1:0];
            dal_oe  = 1'b1;
        end else if (state_r == NCHBP_DATA && write_r) begin
            dal_out = wdata_r;
            dal_oe  = 1'b1;
        end
    end

    assign read_out          = master & ~write_r;
    assign addr_strobe_out   = as_active_high ? as_act : ~as_act;
    assign data_strobe_n_out = ~(state_r == NCHBP_DATA);

    // Transceiver direction; address phase counts as outbound
    assign transceiver_inbound_ctl  = (state_r == NCHBP_DATA) & ~write_r;
    assign transceiver_outbound_ctl = as_act | 
                                      ((state_r == NCHBP_DATA) & write_r);

    // Byte lanes: low lane is even address
    assign lo_lane = ~byte_r | ~addr_r[0];
    assign hi_lane = ~byte_r |  addr_r[0];
    always_comb begin
        if (byte_sel_style) begin
            byte_pin0_out = byte_r;
            byte_pin1_out = 1'b0;
        end else begin
            byte_pin0_out = ~lo_lane;
            byte_pin1_out = ~hi_lane;
        end
    end

    // Interrupt flags
    always_comb begin
        all_set           = event_set;
        all_set[FLG_MEMERR] = event_set[FLG_MEMERR] | err_r;
    end

    nchbp_int_flags u_flags (
        .core_clk             (core_clk),
        .rst                  (rst),
        .flag_set             (all_set),
        .flag_clr             (flag_clr),
        .interrupt_enable_bit (interrupt_enable_bit),
        .flags_r              (flags),
        .attention_request_line_summary         (attention_request_line_summary),
        .attention_active     (attention_active)
    );

    // Status word read by the host to find the cause
    always_comb begin
        primary_control_status                 = DATA_RST;
        primary_control_status[CSR_IEN_POS]    = interrupt_enable_bit;
        primary_control_status[CSR_SUM_POS]    = attention_request_line_summary;
        primary_control_status[CSR_INITDONE_POS] = flags[FLG_INITDONE];
        primary_control_status[CSR_TXDONE_POS] = flags[FLG_TXDONE];
        primary_control_status[CSR_RXDONE_POS] = flags[FLG_RXDONE];
        primary_control_status[CSR_MEMERR_POS] = flags[FLG_MEMERR];
        primary_control_status[CSR_MISS_POS]   = flags[FLG_MISS];
        primary_control_status[CSR_BABBLE_POS] = flags[FLG_BABBLE];
    end

    // Open drain: pull low only, so several sources can share the line
    assign attention_request_line_out = 1'b0;
    assign attention_request_line_oe  = attention_active;
endmodule : nchbp_host_port

// *** nchbp_port_checker.sv ***
`timescale 1ns/1ps
module nchbp_port_checker (
    // Clock and reset
    input wire logic                            core_clk,
    input wire logic                            rst,
    // Configuration and requests
    input wire logic                            as_active_high,
    input wire logic                            interrupt_enable_bit,
    input wire logic                            dma_req,
    input wire logic                            dma_ready,
    input wire logic [nchbp_pkg::ADDR_W-1:0]    dma_addr,
    input wire logic                            dma_done,
    input wire logic                            dma_error,
    input wire logic [nchbp_pkg::DATA_W-1:0]    primary_control_status,
    // Bus pins
    input wire logic [nchbp_pkg::DATA_W-1:0]    addr_lo_out,
    input wire logic [nchbp_pkg::HI_ADDR_W-1:0] addr_hi_out,
    input wire logic                            addr_oe,
    input wire logic                            read_out,
    input wire logic                            addr_strobe_out,
    input wire logic                            data_strobe_n_out,
    input wire logic                            transceiver_inbound_ctl,
    input wire logic                            transceiver_outbound_ctl,
    input wire logic                            ctl_oe,
    input wire logic                            attention_request_line_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence take_s; dma_req && dma_ready; endsequence
    sequence addr_ph_s;
        ctl_oe && addr_oe && transceiver_outbound_ctl;
    endsequence
    a_take_addr: assert property (take_s |=> addr_ph_s and
        ({addr_hi_out, addr_lo_out} == $past(dma_addr)))
        else $error("address phase wrong after take");
    // Config may move between cycles, so only judge a settled idle
    a_strobe_idle: assert property (!ctl_oe && $past(!ctl_oe)
        && $stable(as_active_high) |-> addr_strobe_out == !as_active_high)
        else $error("idle address strobe at active level");
    a_inbound_read: assert property (transceiver_inbound_ctl |->
        ctl_oe && read_out && !data_strobe_n_out)
        else $error("inbound control outside read data");
    a_dir_excl: assert property (!(transceiver_inbound_ctl
        && transceiver_outbound_ctl)) else $error("both directions on");
    a_write_out: assert property (ctl_oe && !read_out |->
        transceiver_outbound_ctl) else $error("write without outbound");
    a_enable_bit: assert property (primary_control_status[6] ==
        interrupt_enable_bit) else $error("enable bit not shown");
    a_summary_any: assert property (primary_control_status[7] ==
        |{primary_control_status[14], primary_control_status[12:8]})
        else $error("summary bit wrong");
    a_attn_gate: assert property (attention_request_line_oe ==
        (interrupt_enable_bit && primary_control_status[7]))
        else $error("attention line wrong");
    a_memory_error_flag_raise: assert property (dma_error |-> dma_done
        ##1 primary_control_status[11]) else $error("timeout not flagged");
endmodule : nchbp_port_checker
bind nchbp_host_port nchbp_port_checker chk_u (.*);

// *** nchbp_mem_model.sv ***
`timescale 1ns/1ps
module nchbp_mem_model (
    // Clock
    input wire logic                       core_clk,
    // Bus pins from the port
    input wire logic [nchbp_pkg::DATA_W-1:0] dal_out,
    input wire logic                       dal_oe,
    input wire logic [nchbp_pkg::DATA_W-1:0] addr_lo_out,
    input wire logic                       ctl_oe,
    input wire logic                       read_out,
    input wire logic                       data_strobe_n_out,
    // Test controls
    input wire logic [3:0]                 lat,
    input wire logic                       mute,
    // Answers
    output logic     [nchbp_pkg::DATA_W-1:0] dal_in,
    output logic                           ready_n
);
    logic [15:0] mem [16];
    logic [15:0] last_r = 16'h0000;
    logic [3:0]  a_r = 4'h0;
    logic [3:0]  cnt_r = 4'h0;
    logic        ds;
    assign ds = ctl_oe && !data_strobe_n_out;
    assign ready_n = !(ds && !mute && cnt_r >= lat);
    // Undriven bus never repeats the last word, so stale reads show up
    assign dal_in = (ds && read_out) ? mem[a_r] : ~last_r;
    always_ff @(posedge core_clk) begin
        cnt_r <= ds ? cnt_r + 4'h1 : 4'h0;
        last_r <= dal_in;
        if (ctl_oe && data_strobe_n_out) begin
            a_r <= dal_oe ? dal_out[3:0] : addr_lo_out[3:0];
        end
        if (ds && !read_out && !ready_n) begin
            mem[a_r] <= dal_out;
        end
    end
endmodule : nchbp_mem_model

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import nchbp_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, mute = 1'b0, err_seen;
    logic byte_sel_style = 1'b0, as_active_high = 1'b0, demux_bus = 1'b0;
    logic interrupt_enable_bit = 1'b0, dma_req = 1'b0;
    logic dma_write = 1'b0, dma_byte = 1'b0;
    logic [3:0]           lat = 4'h0;
    logic [ADDR_W-1:0]    dma_addr = ADDR_RST;
    logic [DATA_W-1:0]    dma_wdata = DATA_RST, dma_rdata, dal_in, dal_out;
    logic [DATA_W-1:0]    primary_control_status, addr_lo_out;
    logic [NUM_FLAGS-1:0] event_set = FLAGS_RST, flag_clr = FLAGS_RST;
    logic [HI_ADDR_W-1:0] addr_hi_out;
    logic dma_ready, dma_done, dma_error, dal_oe, addr_oe, read_out, ctl_oe;
    logic addr_strobe_out, data_strobe_n_out, byte_pin0_out, byte_pin1_out;
    logic transceiver_inbound_ctl, transceiver_outbound_ctl, ready_n;
    logic attention_request_line_out, attention_request_line_oe;
    int err_count = 0, n_checks = 0;
    int pos [6] = '{CSR_BABBLE_POS, CSR_MISS_POS, CSR_MEMERR_POS,
                    CSR_RXDONE_POS, CSR_TXDONE_POS, CSR_INITDONE_POS};
    nchbp_host_port dut_u (.*);
    nchbp_mem_model mem_u (.*);
    initial forever #4 core_clk = ~core_clk;
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic xfer(input logic wr, by, input logic [23:0] a,
                        input logic [15:0] d);
        int n;
        @(posedge core_clk);
        dma_req <= 1'b1;
        dma_write <= wr;
        dma_byte <= by;
        dma_addr <= a;
        dma_wdata <= d;
        @(posedge core_clk);
        dma_req <= 1'b0;
        @(negedge core_clk);
        chk({addr_hi_out, addr_lo_out}, a);
        chk(addr_strobe_out, as_active_high);
        chk({dal_oe, dal_out & {16{dal_oe}}},
            {!demux_bus, a[15:0] & {16{!demux_bus}}});
        @(negedge core_clk);
        chk({transceiver_inbound_ctl, transceiver_outbound_ctl},
            {!wr, wr});
        chk({byte_pin1_out, byte_pin0_out}, byte_sel_style ? {1'b0, by}
            : (by ? (a[0] ? 2'h1 : 2'h2) : 2'h0));
        for (n = 0; n < 4000 && dma_done !== 1'b1; n++) @(negedge core_clk);
        if (n == 4000) begin
            err_count++;
            close_out();
        end
        err_seen = dma_error;
    endtask : xfer
    initial begin
        logic [23:0] a;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk({dma_ready, primary_control_status}, 24'h01_0000);
        // Every mix of style, bus mode and polarity, memory wait set to the mix index m
        for (int m = 0; m < 8; m++) begin
            a = 24'hC3_5A00 + 24'(2 * m);
            @(posedge core_clk);
            {byte_sel_style, demux_bus, as_active_high} <= m[2:0];
            lat <= m[3:0];
            xfer(1'b1, 1'b0, a, 16'hBEE0 + 16'(m));
            xfer(1'b0, 1'b0, a, 16'h0000);
            chk(dma_rdata, 16'hBEE0 + 16'(m));
            xfer(1'b1, 1'b1, a + 24'h00_0001, 16'h0077);
            xfer(1'b0, 1'b1, a, 16'h0000);
            chk(err_seen, 1'b0);
        end
        // Silent memory: handshake timeout path
        @(posedge core_clk);
        mute <= 1'b1;
        xfer(1'b0, 1'b0, 24'hFF_FFFE, 16'h0000);
        chk(err_seen, 1'b1);
        @(posedge core_clk);
        mute <= 1'b0;
        @(negedge core_clk);
        chk(primary_control_status, 16'h0880);
        @(posedge core_clk);
        flag_clr <= 6'h04;
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            flag_clr <= 6'h00;
            interrupt_enable_bit <= i[0];
            event_set <= 6'(1 << i);
            @(posedge core_clk);
            event_set <= 6'h00;
            @(negedge core_clk);
            chk(primary_control_status, 16'(1 << pos[i]) | 16'h0080
                | (i[0] ? 16'h0040 : 16'h0000));
            chk({attention_request_line_out, attention_request_line_oe},
                {1'b0, i[0]});
            @(posedge core_clk);
            flag_clr <= 6'(1 << i);
            @(posedge core_clk);
            flag_clr <= 6'h00;
            @(negedge core_clk);
            chk({primary_control_status, attention_request_line_oe},
                {i[0] ? 16'h0040 : 16'h0000, 1'b0});
        end
        close_out();
    end
endmodule : tb_top
